/* File: hw/toc_chan.sv */
// One compare channel: match detection and pin action
`timescale 1ns/100ps
module toc_chan
   import toc_pkg::*;
(
   // Counter and channel setup
   input  wire logic [CNT_W-1:0] count,
   input  wire logic [CNT_W-1:0] cmp,
   input  wire logic             dir,
   input  wire toc_act_e         act,
   // Events
   input  wire logic             tick,
   input  wire logic             force_pulse,
   input  wire logic             level,
   // Results
   output logic                  match,
   output logic                  fire,
   output logic                  next_level
);

   // ---------------------------------------------------------------
   // Match and fire
   // ---------------------------------------------------------------
   assign match = dir & tick & (count == cmp);
   assign fire  = match | (dir & force_pulse);

   // ---------------------------------------------------------------
   // Pin action
   // ---------------------------------------------------------------
   always_comb begin
      unique case (act)
         ACT_OFF:    next_level = level;
         ACT_TOGGLE: next_level = ~level;
         ACT_CLEAR:  next_level = 1'b0;
         ACT_SET:    next_level = 1'b1;
      endcase
   end

endmodule : toc_chan

/* File: hw/toc_pkg.sv */
// Shared constants and types of the output compare and interrupt block
package toc_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_CH  = 4;
   localparam int CNT_W   = 16;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_DIR    = 8'h00;
   localparam logic [ADDR_W-1:0] A_ACTION = 8'h01;
   localparam logic [ADDR_W-1:0] A_IEN    = 8'h02;
   localparam logic [ADDR_W-1:0] A_FLAG1  = 8'h03;
   localparam logic [ADDR_W-1:0] A_FLAG2  = 8'h04;
   localparam logic [ADDR_W-1:0] A_FORCE  = 8'h05;
   localparam logic [ADDR_W-1:0] A_MASK3  = 8'h06;
   localparam logic [ADDR_W-1:0] A_DATA3  = 8'h07;
   localparam logic [ADDR_W-1:0] A_SYSCTL = 8'h08;
   localparam logic [ADDR_W-1:0] A_PORT   = 8'h09;
   localparam logic [ADDR_W-1:0] A_WAKE   = 8'h0A;
   localparam logic [ADDR_W-1:0] A_COUNT  = 8'h0B;
   localparam logic [ADDR_W-1:0] A_CMP0   = 8'h10;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int WRAP_BIT  = 7;
   localparam int CLR_BIT   = 0;

   // ---------------------------------------------------------------
   // Reset values and fixed counts
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF;
   localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
   localparam logic [NUM_CH-1:0] CH_RST   = 4'h0;
   localparam logic [DATA_W-1:0] RD_RST   = 16'h0000;

   // ---------------------------------------------------------------
   // Pin action codes, {mode, level}
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ACT_OFF    = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR  = 2'b10,
      ACT_SET    = 2'b11
   } toc_act_e;

   // ---------------------------------------------------------------
   // Register bus request
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } toc_bus_s;

   // ---------------------------------------------------------------
   // Interrupt and wake requests
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0] chan;
      logic              wrap;
      logic              wake;
   } toc_irq_s;

endpackage : toc_pkg

/* File: hw/toc_top.sv */
// Four-channel timer output compare with interrupt requests
// Summary of operation
// - direction bit one puts the channel in output compare use.
// - counter equal to channel value sets, clears or toggles the pin.
// - mode and level bits pick the action; both zero disconnects pin unless, on channels 0 to 2, its channel 3 mask bit is set.
// - every compare match sets that channel's event flag.
// - event flag requests interrupt only while channel enable is one.
// - force bit performs the pin action at once, flag untouched.
// - channel 3 compare beats other channels' actions in the same cycle.
// - channel 3 mask picks which channel 3 data bits drive other pins.
// - with clear enable set, channel 3 match resets the counter.
// - port writes to a compare pin only update an internal latch.
// - a released pin shows the last latched port value.
// - four active-high channel requests, gated by their enables.
// - six request lines total: four channels, wrap and wake.
// - wrap request asserts after wrap while its enable is one.
// - compare wake routing works in every power mode.
// - wrap flag sets when the counter rolls from all ones to zero.
// - writing one clears the wrap flag; zero leaves it.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module toc_top
   import toc_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                ce,
   // Prescaled counter tick
   input  wire logic                tick,
   // Register port
   input  wire toc_bus_s            bus,
   output logic [DATA_W-1:0]        rd_data,
   // Channel pins
   input  wire logic [NUM_CH-1:0]   gpio_drive_en,
   output logic [NUM_CH-1:0]        pin_out,
   output logic [NUM_CH-1:0]        pin_oe,
   // Counter and requests
   output logic [CNT_W-1:0]         count_value,
   output toc_irq_s                 irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0]             count;
      logic [NUM_CH-1:0][CNT_W-1:0] cmp;
      logic [NUM_CH-1:0]            dir;
      logic [2*NUM_CH-1:0]          act;
      logic [NUM_CH-1:0]            chan_ien;
      logic                         wrap_ien;
      logic [NUM_CH-1:0]            flag;
      logic                         wflag;
      logic [NUM_CH-1:0]            mask3;
      logic [NUM_CH-1:0]            data3;
      logic                         clr_en;
      logic [NUM_CH-1:0]            port;
      logic [NUM_CH-1:0]            route;
      logic [NUM_CH-1:0]            level;
      logic                         wake;
      logic [DATA_W-1:0]            rdata;
   } toc_state_s;

   toc_state_s           s;
   toc_state_s           next_s;
   logic [NUM_CH-1:0]    match;
   logic [NUM_CH-1:0]    fire;
   logic [NUM_CH-1:0]    new_level;
   logic [NUM_CH-1:0]    force_pulse;
   logic [NUM_CH-1:0]    in_use;
   logic [NUM_CH-1:0]    flag_clr;
   logic                 wflag_clr;
   logic                 wrap_evt;
   logic                 cnt_reset;

   // ---------------------------------------------------------------
   // Write decode for one-shot effects
   // ---------------------------------------------------------------
   always_comb begin
      force_pulse = CH_RST;
      flag_clr    = CH_RST;
      wflag_clr   = 1'b0;
      if (bus.wr) begin
         if (bus.addr == A_FORCE) begin
            force_pulse = bus.wdata[NUM_CH-1:0];
         end
         if (bus.addr == A_FLAG1) begin
            flag_clr = bus.wdata[NUM_CH-1:0];
         end
         if (bus.addr == A_FLAG2) begin
            wflag_clr = bus.wdata[WRAP_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         toc_chan u_chan (
            .count       (s.count),
            .cmp         (s.cmp[g]),
            .dir         (s.dir[g]),
            .act         (toc_act_e'(s.act[2*g+1 -: 2])),
            .tick        (tick),
            .force_pulse (force_pulse[g]),
            .level       (s.level[g]),
            .match       (match[g]),
            .fire        (fire[g]),
            .next_level  (new_level[g])
         );
         // Pin belongs to compare logic when an action or mask drives it
         assign in_use[g] = s.dir[g] &&
                            ((s.act[2*g+1 -: 2] != ACT_OFF) ||
                             ((g != NUM_CH-1) && s.mask3[g]));
      end
   endgenerate

   assign cnt_reset = match[NUM_CH-1] & s.clr_en;
   assign wrap_evt  = tick & ~cnt_reset & (s.count == CNT_MAX);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;

      // Register writes
      if (bus.wr) begin
         unique case (bus.addr)
            A_DIR:    next_s.dir      = bus.wdata[NUM_CH-1:0];
            A_ACTION: next_s.act      = bus.wdata[2*NUM_CH-1:0];
            A_IEN: begin
               next_s.chan_ien = bus.wdata[NUM_CH-1:0];
               next_s.wrap_ien = bus.wdata[WRAP_BIT];
            end
            A_MASK3:  next_s.mask3    = bus.wdata[NUM_CH-1:0];
            A_DATA3:  next_s.data3    = bus.wdata[NUM_CH-1:0];
            A_SYSCTL: next_s.clr_en   = bus.wdata[CLR_BIT];
            A_PORT:   next_s.port     = bus.wdata[NUM_CH-1:0];
            A_WAKE:   next_s.route    = bus.wdata[NUM_CH-1:0];
            default: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (bus.addr == A_CMP0 + ADDR_W'(i) && s.dir[i]) begin
                     next_s.cmp[i] = bus.wdata[CNT_W-1:0];
                  end
               end
            end
         endcase
      end

      // Pin actions, channel 3 override last so it wins
      for (int i = 0; i < NUM_CH; i++) begin
         if (fire[i]) begin
            next_s.level[i] = new_level[i];
         end
      end
      if (fire[NUM_CH-1]) begin
         for (int i = 0; i < NUM_CH-1; i++) begin
            if (s.mask3[i]) begin
               next_s.level[i] = s.data3[i];
            end
         end
      end

      // Counter
      if (tick) begin
         if (cnt_reset) begin
            next_s.count = CNT_RST;
         end else begin
            next_s.count = s.count + CNT_ONE;
         end
      end

      // Flags: set wins over clear
      next_s.flag  = (s.flag & ~flag_clr) | match;
      next_s.wflag = (s.wflag & ~wflag_clr) | wrap_evt;

      // Wake routing, independent of power mode
      next_s.wake  = |(match & s.route);

      // Read data, one cycle after the strobe
      next_s.rdata = RD_RST;
      if (bus.rd) begin
         unique case (bus.addr)
            A_DIR:    next_s.rdata[NUM_CH-1:0]   = s.dir;
            A_ACTION: next_s.rdata[2*NUM_CH-1:0] = s.act;
            A_IEN: begin
               next_s.rdata[NUM_CH-1:0] = s.chan_ien;
               next_s.rdata[WRAP_BIT]   = s.wrap_ien;
            end
            A_FLAG1:  next_s.rdata[NUM_CH-1:0]   = s.flag;
            A_FLAG2:  next_s.rdata[WRAP_BIT]     = s.wflag;
            A_MASK3:  next_s.rdata[NUM_CH-1:0]   = s.mask3;
            A_DATA3:  next_s.rdata[NUM_CH-1:0]   = s.data3;
            A_SYSCTL: next_s.rdata[CLR_BIT]      = s.clr_en;
            A_PORT:   next_s.rdata[NUM_CH-1:0]   = s.port;
            A_WAKE:   next_s.rdata[NUM_CH-1:0]   = s.route;
            A_COUNT:  next_s.rdata               = s.count;
            default: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (bus.addr == A_CMP0 + ADDR_W'(i)) begin
                     next_s.rdata = s.cmp[i];
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign rd_data     = s.rdata;
   assign count_value = s.count;
   assign pin_out     = (in_use & s.level) | (~in_use & s.port);
   assign pin_oe      = in_use | gpio_drive_en;
   assign irq.chan    = s.flag & s.chan_ien;
   assign irq.wrap    = s.wflag & s.wrap_ien;
   assign irq.wake    = s.wake;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_match_flag;
      @(posedge clock) disable iff (!rst_n)
      (ce && match != CH_RST) |=> ((s.flag & $past(match)) == $past(match));
   endproperty
   a_match_flag: assert property (p_match_flag)
      else $error("match did not set its flag");

   property p_force_no_flag;
      @(posedge clock) disable iff (!rst_n)
      (ce && bus.wr && bus.addr == A_FORCE && bus.wdata[0] && !match[0]
       && !s.flag[0]) |=> !s.flag[0];
   endproperty
   a_force_no_flag: assert property (p_force_no_flag)
      else $error("forced compare set a flag");

   property p_irq_gate;
      @(posedge clock) disable iff (!rst_n)
      (s.chan_ien == CH_RST) |-> (irq.chan == CH_RST);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("channel request without enable");

   property p_toggle;
      @(posedge clock) disable iff (!rst_n)
      (ce && match[0] && s.act[1:0] == ACT_TOGGLE && !fire[NUM_CH-1])
      |=> (s.level[0] != $past(s.level[0]));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle action missing");

   property p_ch3_wins;
      @(posedge clock) disable iff (!rst_n)
      (ce && fire[NUM_CH-1] && fire[1] && s.mask3[1])
      |=> (s.level[1] == $past(s.data3[1]));
   endproperty
   a_ch3_wins: assert property (p_ch3_wins)
      else $error("channel 3 override lost");

   property p_cnt_reset;
      @(posedge clock) disable iff (!rst_n)
      (ce && tick && match[NUM_CH-1] && s.clr_en) |=> (s.count == CNT_RST);
   endproperty
   a_cnt_reset: assert property (p_cnt_reset)
      else $error("counter not reset on channel 3 match");

   property p_wrap_set;
      @(posedge clock) disable iff (!rst_n)
      (ce && wrap_evt) |=> (s.wflag && s.count == CNT_RST);
   endproperty
   a_wrap_set: assert property (p_wrap_set)
      else $error("wrap flag not set");

   property p_wrap_clear;
      @(posedge clock) disable iff (!rst_n)
      (ce && wflag_clr && !wrap_evt) |=> !s.wflag;
   endproperty
   a_wrap_clear: assert property (p_wrap_clear)
      else $error("wrap flag not cleared");

   property p_wrap_irq;
      @(posedge clock) disable iff (!rst_n)
      (ce && wrap_evt && s.wrap_ien && !bus.wr) |=> irq.wrap;
   endproperty
   a_wrap_irq: assert property (p_wrap_irq)
      else $error("wrap request missing");

   property p_port_latch;
      @(posedge clock) disable iff (!rst_n)
      (ce && bus.wr && bus.addr == A_PORT && in_use[0] && !fire[0]
       && !fire[NUM_CH-1]) |=> (pin_out[0] == $past(pin_out[0]));
   endproperty
   a_port_latch: assert property (p_port_latch)
      else $error("port write moved a compare pin");

   property p_wake_pulse;
      @(posedge clock) disable iff (!rst_n)
      (ce && (match & s.route) != CH_RST) |=> irq.wake;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("routed match gave no wake pulse");

   property p_cmp_locked;
      @(posedge clock) disable iff (!rst_n)
      (ce && bus.wr && bus.addr == A_CMP0 && !s.dir[0])
      |=> (s.cmp[0] == $past(s.cmp[0]));
   endproperty
   a_cmp_locked: assert property (p_cmp_locked)
      else $error("compare value changed in capture use");

   property p_flag_clear;
      @(posedge clock) disable iff (!rst_n)
      (ce && flag_clr[0] && !match[0]) |=> !s.flag[0];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("channel flag not cleared");

   property p_cnt_restart;
      @(posedge clock) disable iff (!rst_n)
      (ce && tick && s.count == CNT_RST && !cnt_reset)
      |=> (s.count == CNT_ONE);
   endproperty
   a_cnt_restart: assert property (p_cnt_restart)
      else $error("counter did not restart from zero");

endmodule : toc_top

/* File: tb/toc_pins_model.sv */
// Channel pin pads as seen from the board side
`timescale 1ns/100ps
module toc_pins_model
   import toc_pkg::*;
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // Pin drivers of the block
   input  wire logic [NUM_CH-1:0] pin_out,
   input  wire logic [NUM_CH-1:0] pin_oe,
   // Pad levels
   output logic [NUM_CH-1:0]      pad
);
   // ---------------------------------------------------------------
   // Undriven pads float away from the last driven level
   // ---------------------------------------------------------------
   logic [NUM_CH-1:0] last;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         last <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (pin_oe[i]) begin
               last[i] <= pin_out[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         pad[i] = pin_oe[i] ? pin_out[i] : ~last[i];
      end
   end
endmodule : toc_pins_model

/* File: tb/toc_top_tb.sv */
// Self-checking bench of the output compare and interrupt block
`timescale 1ns/100ps
module toc_top_tb
   import toc_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   typedef struct packed {
      toc_act_e act;
      logic     pin;
   } toc_row_s;

   logic              clock;
   logic              rst_n;
   logic              ce;
   logic              tick;
   toc_bus_s          bus;
   logic [DATA_W-1:0] rd_data;
   logic [NUM_CH-1:0] gpio_drive_en;
   logic [NUM_CH-1:0] pin_out;
   logic [NUM_CH-1:0] pin_oe;
   logic [NUM_CH-1:0] pad;
   logic [CNT_W-1:0]  count_value;
   toc_irq_s          irq;
   logic [CNT_W-1:0]  cnt;
   logic [DATA_W-1:0] rv;
   logic [CNT_W-1:0]  last_cmp;
   int                miscompares;
   int                samples_checked;
   toc_row_s          rows [5];

   // ---------------------------------------------------------------
   // Instances and clock
   // ---------------------------------------------------------------
   toc_top toc_top_inst (.clock(clock), .rst_n(rst_n), .ce(ce), .tick(tick),
      .bus(bus), .rd_data(rd_data), .gpio_drive_en(gpio_drive_en),
      .pin_out(pin_out), .pin_oe(pin_oe), .count_value(count_value),
      .irq(irq));

   toc_pins_model toc_pins_model_inst (.clock(clock), .rst_n(rst_n),
      .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

   always #2.5 clock = ~clock;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [DATA_W-1:0] seen,
                      input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus <= '0;
      #1;
   endtask : wr

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clock);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus <= '0;
      #1;
      rv = rd_data;
      chk(rv, e);
   endtask : rdc

   task automatic tick_n(input int n);
      @(posedge clock);
      tick <= 1'b1;
      repeat (n) @(posedge clock);
      tick <= 1'b0;
      cnt = cnt + 16'(n);
      #1;
   endtask : tick_n

   task automatic stop_test();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   initial begin
      #500_000;
      miscompares++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      tick = 1'b0;
      bus = '0;
      gpio_drive_en = 4'h1;
      cnt = '0;
      miscompares = 0;
      samples_checked = 0;
      rows = '{'{ACT_SET, 1'b1}, '{ACT_TOGGLE, 1'b0}, '{ACT_TOGGLE, 1'b1},
               '{ACT_CLEAR, 1'b0}, '{ACT_OFF, 1'b1}};
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      // Channel 0 setup, port latch written while in compare use
      wr(A_DIR, 16'h0001);
      wr(A_IEN, 16'h0001);
      wr(A_ACTION, 16'h0002);
      wr(A_PORT, 16'h0001);
      chk(16'(pad[0]), 16'h0000);
      // Action table
      foreach (rows[i]) begin
         wr(A_ACTION, {14'h0000, rows[i].act});
         last_cmp = cnt;
         wr(A_CMP0, cnt);
         tick_n(1);
         chk(16'(pad[0]), 16'(rows[i].pin));
         chk(16'(pin_oe[0]), 16'h0001);
         chk(16'(irq.chan), 16'h0001);
         rdc(A_FLAG1, 16'h0001);
         wr(A_FLAG1, 16'h0001);
         rdc(A_FLAG1, 16'h0000);
         chk(16'(irq.chan), 16'h0000);
      end
      // Compare value locked while channel is in capture use
      wr(A_DIR, 16'h0000);
      wr(A_CMP0, 16'h1234);
      rdc(A_CMP0, last_cmp);
      chk(16'(pin_oe[0]), 16'(gpio_drive_en[0]));
      // Writes with clock enable low are dropped
      @(posedge clock);
      ce <= 1'b0;
      wr(A_DIR, 16'h000F);
      @(posedge clock);
      ce <= 1'b1;
      rdc(A_DIR, 16'h0000);
      // Forced compare: action without flag
      wr(A_DIR, 16'h000F);
      wr(A_IEN, 16'h0000);
      wr(A_ACTION, 16'h007C);
      wr(A_FORCE, 16'h0002);
      chk(16'(pin_out[1]), 16'h0001);
      rdc(A_FLAG1, 16'h0000);
      rdc(A_FORCE, 16'h0000);
      // Channel 3 override, counter clear and wake routing
      wr(A_MASK3, 16'h0002);
      wr(A_DATA3, 16'h0000);
      wr(A_SYSCTL, 16'h0001);
      wr(A_WAKE, 16'h0008);
      for (int i = 1; i < NUM_CH; i++) begin
         wr(ADDR_W'(A_CMP0 + i), cnt);
      end
      tick_n(1);
      cnt = '0;
      chk(16'(pin_out[3:1]), 16'h0006);
      chk(16'(irq.wake), 16'h0001);
      chk(16'(irq.chan), 16'h0000);
      @(posedge clock);
      #1;
      chk(16'(irq.wake), 16'h0000);
      rdc(A_FLAG1, 16'h000E);
      rdc(A_COUNT, cnt);
      chk(count_value, cnt);
      tick_n(1);
      rdc(A_COUNT, cnt);
      chk(count_value, cnt);
      wr(A_IEN, 16'h0008);
      chk(16'(irq.chan), 16'h0008);
      @(posedge clock);
      gpio_drive_en <= 4'h0;
      #1;
      chk(16'(pin_oe[0]), 16'h0000);
      // Counter wrap
      wr(A_SYSCTL, 16'h0000);
      wr(A_IEN, 16'h0080);
      wr(A_FLAG1, 16'h000F);
      tick_n(int'(CNT_MAX - cnt));
      rdc(A_FLAG2, 16'h0000);
      chk(16'(irq.wrap), 16'h0000);
      tick_n(1);
      chk(16'(irq.wrap), 16'h0001);
      rdc(A_FLAG2, 16'h0080);
      rdc(A_COUNT, cnt);
      chk(count_value, cnt);
      wr(A_FLAG2, 16'h0000);
      rdc(A_FLAG2, 16'h0080);
      wr(A_FLAG2, 16'h0080);
      rdc(A_FLAG2, 16'h0000);
      chk(16'(irq.wrap), 16'h0000);
      // Second reset and reset values, unmapped places read zero
      @(posedge clock);
      rst_n <= 1'b0;
      gpio_drive_en <= 4'h5;
      repeat (6) @(posedge clock);
      #1;
      chk(16'(pin_oe), 16'h0005);
      chk(16'(irq), 16'h0000);
      @(posedge clock);
      rst_n <= 1'b1;
      for (int a = 0; a < 32'h21; a++) begin
         rdc(ADDR_W'(a), 16'h0000);
      end
      stop_test();
   end
endmodule : toc_top_tb
